// ---- core/fbh_host.v ----
// host controller driving a byte-wide sector flash through its bus pins
`timescale 1ns/1ps
`include "fbh_consts.vh"

module fbh_host #(
    parameter ACCESS_CYC = `FBH_ACCESS_CYC,
    parameter PULSE_CYC  = `FBH_PULSE_CYC
) (
    input  wire                    ref_clk_i,
    input  wire                    rstn_i,
    input  wire                    ce_i,
    input  wire                    req_valid_i,
    output wire                    req_ready_o,
    input  wire [2:0]              req_op_i,
    input  wire [`FBH_ADDR_W-1:0]  req_addr_i,
    input  wire [`FBH_DATA_W-1:0]  req_data_i,
    output reg                     rsp_valid_o,
    output reg  [`FBH_DATA_W-1:0]  rsp_data_o,
    output reg                     id_mode_o,
    output reg  [`FBH_ADDR_W-1:0]  flash_addr_o,
    output wire [`FBH_DATA_W-1:0]  flash_dq_o,
    output wire                    flash_dq_oe_o,
    input  wire [`FBH_DATA_W-1:0]  flash_dq_i,
    output wire                    flash_ce_n_o,
    output wire                    flash_oe_n_o,
    output wire                    flash_we_n_o,
    output reg                     flash_hv_id_o
);
    localparam S_IDLE = 2'h0;
    localparam S_ISSUE = 2'h1;
    localparam S_WAIT = 2'h2;

    reg  [1:0]             state;
    reg  [2:0]             op;
    reg  [2:0]             step;
    reg  [2:0]             last_step;
    reg  [`FBH_ADDR_W-1:0] op_addr;
    reg  [`FBH_DATA_W-1:0] op_data;
    reg                    cyc_start;
    reg                    cyc_write;
    reg  [`FBH_ADDR_W-1:0] cyc_addr;
    reg  [`FBH_DATA_W-1:0] cyc_wdata;
    wire                   cyc_done;
    wire [`FBH_DATA_W-1:0] cyc_rdata;
    wire [`FBH_ADDR_W-1:0] eng_addr;

    assign req_ready_o = (state == S_IDLE);

    // pins carry the engine address, settled a cycle before any strobe falls
    always @* begin
        flash_addr_o = eng_addr;
    end

    // sequence step table: address and data of each bus cycle
    always @* begin
        cyc_write = 1'b1;
        cyc_addr  = `FBH_UNLOCK1_ADDR;
        cyc_wdata = `FBH_UNLOCK1_DATA;
        last_step = 3'h0;
        case (op)
            `FBH_OP_READ, `FBH_OP_HV_ID: begin
                cyc_write = 1'b0;
                cyc_addr  = op_addr;
            end
            `FBH_OP_WRITE: begin
                cyc_addr  = op_addr;
                cyc_wdata = op_data;
            end
            `FBH_OP_RESET: begin
                cyc_wdata = `FBH_CMD_RESET;
            end
            `FBH_OP_AUTOSEL, `FBH_OP_PROGRAM: begin
                last_step = (op == `FBH_OP_PROGRAM) ? 3'h3 : 3'h2;
                case (step)
                    3'h0: cyc_addr = `FBH_UNLOCK1_ADDR;
                    3'h1: begin
                        cyc_addr  = `FBH_UNLOCK2_ADDR;
                        cyc_wdata = `FBH_UNLOCK2_DATA;
                    end
                    3'h2: cyc_wdata = (op == `FBH_OP_PROGRAM) ? `FBH_CMD_PROGRAM
                                                              : `FBH_CMD_AUTOSEL;
                    default: begin
                        cyc_addr  = op_addr;
                        cyc_wdata = op_data;
                    end
                endcase
            end
            default: begin
                last_step = 3'h5;
                case (step)
                    3'h1, 3'h4: begin
                        cyc_addr  = `FBH_UNLOCK2_ADDR;
                        cyc_wdata = `FBH_UNLOCK2_DATA;
                    end
                    3'h2: cyc_wdata = `FBH_CMD_ERASE;
                    3'h5: begin
                        if (op == `FBH_OP_SECT_ERASE) begin
                            // sector chosen by the top three address bits
                            cyc_addr  = {op_addr[`FBH_SECT_HI:`FBH_SECT_LO],
                                         {`FBH_SECT_LO{1'b0}}};
                            cyc_wdata = `FBH_CMD_SECTOR;
                        end else begin
                            cyc_wdata = `FBH_CMD_CHIP;
                        end
                    end
                    default: cyc_wdata = `FBH_UNLOCK1_DATA;
                endcase
            end
        endcase
    end

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state         <= S_IDLE;
            op            <= `FBH_OP_READ;
            step          <= 3'h0;
            op_addr       <= {`FBH_ADDR_W{1'b0}};
            op_data       <= {`FBH_DATA_W{1'b0}};
            cyc_start     <= 1'b0;
            rsp_valid_o   <= 1'b0;
            rsp_data_o    <= {`FBH_DATA_W{1'b0}};
            id_mode_o     <= 1'b0;
            flash_hv_id_o <= 1'b0;
        end else if (ce_i) begin
            rsp_valid_o <= 1'b0;
            cyc_start   <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (req_valid_i) begin
                        op      <= req_op_i;
                        op_addr <= req_addr_i;
                        op_data <= req_data_i;
                        step    <= 3'h0;
                        // separate qualifier, low a6 for the id decode
                        flash_hv_id_o <= (req_op_i == `FBH_OP_HV_ID);
                        state   <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    cyc_start <= 1'b1;
                    state     <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        if (step == last_step) begin
                            rsp_valid_o   <= 1'b1;
                            rsp_data_o    <= cyc_rdata;
                            flash_hv_id_o <= 1'b0;
                            if (op == `FBH_OP_AUTOSEL)
                                id_mode_o <= 1'b1;
                            else if (op == `FBH_OP_RESET)
                                id_mode_o <= 1'b0;
                            state <= S_IDLE;
                        end else begin
                            step  <= step + 3'h1;
                            state <= S_ISSUE;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // hv id reads force a6 low, other bits pass through
    wire [`FBH_ADDR_W-1:0] cyc_addr_q;
    assign cyc_addr_q = (op == `FBH_OP_HV_ID) ?
                        (cyc_addr & ~({{(`FBH_ADDR_W-1){1'b0}}, 1'b1} << `FBH_A6_BIT))
                        : cyc_addr;

    fbh_cycle #(
        .ACCESS_CYC (ACCESS_CYC),
        .PULSE_CYC  (PULSE_CYC)
    ) u_cycle (
        .ref_clk_i     (ref_clk_i),
        .rstn_i        (rstn_i),
        .ce_i          (ce_i),
        .start_i       (cyc_start),
        .write_i       (cyc_write),
        .addr_i        (cyc_addr_q),
        .wdata_i       (cyc_wdata),
        .busy_o        (),
        .done_o        (cyc_done),
        .rdata_o       (cyc_rdata),
        .flash_addr_o  (eng_addr),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_o (flash_dq_oe_o),
        .flash_dq_i    (flash_dq_i),
        .flash_ce_n_o  (flash_ce_n_o),
        .flash_oe_n_o  (flash_oe_n_o),
        .flash_we_n_o  (flash_we_n_o)
    );
endmodule

// ---- core/fbh_consts.vh ----
// constants for the parallel flash bus host controller
`ifndef FBH_CONSTS_VH
`define FBH_CONSTS_VH

`define FBH_ADDR_W        19
`define FBH_DATA_W        8
`define FBH_SECT_HI       18
`define FBH_SECT_LO       16
`define FBH_HV_BIT        9
`define FBH_A6_BIT        6
// id low address codes
`define FBH_ID_MAKER      8'h00
`define FBH_ID_DEVICE     8'h01
`define FBH_ID_PROT       8'h02
`define FBH_ID_CONT       8'h03
// command words
`define FBH_UNLOCK1_ADDR  19'h00555
`define FBH_UNLOCK1_DATA  8'haa
`define FBH_UNLOCK2_ADDR  19'h002aa
`define FBH_UNLOCK2_DATA  8'h55
`define FBH_CMD_AUTOSEL   8'h90
`define FBH_CMD_PROGRAM   8'ha0
`define FBH_CMD_ERASE     8'h80
`define FBH_CMD_CHIP      8'h10
`define FBH_CMD_SECTOR    8'h30
`define FBH_CMD_RESET     8'hf0
// host operations
`define FBH_OP_READ       3'h0
`define FBH_OP_WRITE      3'h1
`define FBH_OP_AUTOSEL    3'h2
`define FBH_OP_PROGRAM    3'h3
`define FBH_OP_CHIP_ERASE 3'h4
`define FBH_OP_SECT_ERASE 3'h5
`define FBH_OP_RESET      3'h6
`define FBH_OP_HV_ID      3'h7
// timing
`define FBH_CLK_PS        25000
`define FBH_ACCESS_NS     90
`define FBH_PULSE_NS      50
`define FBH_GLITCH_NS     5
// cycle counts, least times rounded up plus one cycle
`define FBH_ACCESS_CYC    ((`FBH_ACCESS_NS * 1000 + `FBH_CLK_PS - 1) / `FBH_CLK_PS + 1)
`define FBH_PULSE_CYC     ((`FBH_PULSE_NS * 1000 + `FBH_CLK_PS - 1) / `FBH_CLK_PS + 1)
`define FBH_CNT_W         4

`endif

// ---- core/fbh_cycle.v ----
// one bus cycle engine: read or write strobe sequencing on the flash pins
`timescale 1ns/1ps
`include "fbh_consts.vh"

module fbh_cycle #(
    parameter ACCESS_CYC = `FBH_ACCESS_CYC,
    parameter PULSE_CYC  = `FBH_PULSE_CYC
) (
    input  wire                    ref_clk_i,
    input  wire                    rstn_i,
    input  wire                    ce_i,
    input  wire                    start_i,
    input  wire                    write_i,
    input  wire [`FBH_ADDR_W-1:0]  addr_i,
    input  wire [`FBH_DATA_W-1:0]  wdata_i,
    output wire                    busy_o,
    output reg                     done_o,
    output reg  [`FBH_DATA_W-1:0]  rdata_o,
    output reg  [`FBH_ADDR_W-1:0]  flash_addr_o,
    output reg  [`FBH_DATA_W-1:0]  flash_dq_o,
    output reg                     flash_dq_oe_o,
    input  wire [`FBH_DATA_W-1:0]  flash_dq_i,
    output reg                     flash_ce_n_o,
    output reg                     flash_oe_n_o,
    output reg                     flash_we_n_o
);
    localparam S_IDLE  = 2'h0;
    localparam S_SETUP = 2'h1;
    localparam S_PULSE = 2'h2;
    localparam S_HOLD  = 2'h3;

    reg [1:0]            state;
    reg                  is_write;
    reg [`FBH_CNT_W-1:0] cnt;

    assign busy_o = (state != S_IDLE);

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state         <= S_IDLE;
            is_write      <= 1'b0;
            cnt           <= {`FBH_CNT_W{1'b0}};
            done_o        <= 1'b0;
            rdata_o       <= {`FBH_DATA_W{1'b0}};
            flash_addr_o  <= {`FBH_ADDR_W{1'b0}};
            flash_dq_o    <= {`FBH_DATA_W{1'b0}};
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o  <= 1'b1;
            flash_oe_n_o  <= 1'b1;
            flash_we_n_o  <= 1'b1;
        end else if (ce_i) begin
            done_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_i) begin
                        // address settles with oe high before any strobe
                        flash_addr_o  <= addr_i;
                        flash_dq_o    <= wdata_i;
                        flash_dq_oe_o <= write_i;
                        is_write      <= write_i;
                        flash_oe_n_o  <= 1'b1;
                        flash_we_n_o  <= 1'b1;
                        state         <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    flash_ce_n_o <= 1'b0;
                    flash_oe_n_o <= is_write;
                    flash_we_n_o <= ~is_write;
                    // pulses held far above the glitch filter width
                    cnt   <= is_write ? PULSE_CYC[`FBH_CNT_W-1:0] : ACCESS_CYC[`FBH_CNT_W-1:0];
                    state <= S_PULSE;
                end
                S_PULSE: begin
                    if (cnt == {`FBH_CNT_W{1'b0}}) begin
                        if (!is_write)
                            rdata_o <= flash_dq_i;
                        // write data latched at this rising edge
                        flash_we_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        state        <= S_HOLD;
                    end else begin
                        cnt <= cnt - {{(`FBH_CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                S_HOLD: begin
                    flash_ce_n_o  <= 1'b1;
                    flash_dq_oe_o <= 1'b0;
                    done_o        <= 1'b1;
                    state         <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// ---- tb/fbh_flash_model.sv ----
// behavioural byte-wide sector flash answering on its bus pins
`timescale 1ns/1ps
`include "fbh_consts.vh"
module fbh_flash_model #(
    parameter [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter [7:0] DEV_CODE   = 8'hc3, // arbitrary value
    parameter [7:0] CONT_CODE  = 8'h11, // arbitrary value
    parameter [7:0] PROT_MASK  = 8'h00,
    parameter       BUSY_NS    = 600
) (
    input  wire        ce_n_i,
    input  wire        oe_n_i,
    input  wire        we_n_i,
    input  wire        hv_id_i,
    input  wire [18:0] addr_i,
    input  wire [7:0]  dq_i,
    output logic [7:0] dq_o
);
    logic [7:0]  mem [0:524287];
    logic [18:0] wa;
    logic [7:0]  last, pd;
    logic [1:0]  st;
    logic        id_mode, busy, arm;
    realtime     t_fall;
    initial begin
        for (int i = 0; i < 524288; i++)
            mem[i] = 8'hff;
        st = 2'h0;
        {id_mode, busy, arm, last, pd} = '0;
        t_fall = 1.0e9;
    end
    function automatic logic [7:0] rd(input logic [18:0] a);
        if ((hv_id_i && !a[`FBH_A6_BIT]) || id_mode) begin
            case (a[1:0])
                2'h0: return MAKER_CODE;
                2'h1: return DEV_CODE;
                2'h2: return {7'h00, PROT_MASK[a[18:16]]};
                default: return CONT_CODE;
            endcase
        end
        if (busy)
            return {~pd[7], 7'h00};
        return mem[a];
    endfunction
    always @(ce_n_i, oe_n_i, addr_i, busy, id_mode, hv_id_i) begin
        if (!ce_n_i && !oe_n_i) begin
            dq_o = rd(addr_i);
            last = dq_o;
        end else
            dq_o = ~last;
    end
    task automatic erase(input int lo, input int hi);
        for (int i = lo; i <= hi; i++)
            if (!PROT_MASK[i[18:16]])
                mem[i] = 8'hff;
    endtask
    task automatic cmd(input logic [18:0] a, input logic [7:0] d);
        if (busy)
            return;
        if (d == `FBH_CMD_RESET) begin
            {st, id_mode, arm} = '0;
            return;
        end
        case (st)
            2'h0: st = (a == `FBH_UNLOCK1_ADDR && d == `FBH_UNLOCK1_DATA) ? 2'h1 : 2'h0;
            2'h1: st = (a == `FBH_UNLOCK2_ADDR && d == `FBH_UNLOCK2_DATA) ? 2'h2 : 2'h0;
            2'h2: begin
                st = (!arm && d == `FBH_CMD_PROGRAM) ? 2'h3 : 2'h0;
                id_mode = !arm && d == `FBH_CMD_AUTOSEL;
                if (arm && (d == `FBH_CMD_CHIP || d == `FBH_CMD_SECTOR)) begin
                    pd = 8'hff;
                    busy = 1'b1;
                    busy <= #(BUSY_NS) 1'b0;
                    if (d == `FBH_CMD_CHIP)
                        erase(0, 524287);
                    else
                        erase({a[18:16], 16'h0}, {a[18:16], 16'hffff});
                end
                arm = !arm && d == `FBH_CMD_ERASE;
            end
            default: begin
                st = 2'h0;
                if (!PROT_MASK[a[18:16]]) begin
                    pd = d;
                    mem[a] = mem[a] & d;
                    busy = 1'b1;
                    busy <= #(BUSY_NS) 1'b0;
                end
            end
        endcase
    endtask
    always @(negedge we_n_i) begin
        wa = addr_i;
        t_fall = $realtime;
    end
    always @(posedge we_n_i)
        if (!ce_n_i && oe_n_i && $realtime - t_fall >= `FBH_GLITCH_NS)
            cmd(wa, dq_i);
endmodule

// ---- tb/fbh_host_sva.sv ----
// concurrent checks on the flash host pins
`timescale 1ns/1ps
`include "fbh_consts.vh"
module fbh_host_sva #(
    parameter ACCESS_CYC = `FBH_ACCESS_CYC,
    parameter PULSE_CYC  = `FBH_PULSE_CYC
) (
    input wire                   ref_clk_i,
    input wire                   rstn_i,
    input wire                   ce_i,
    input wire                   req_valid_i,
    input wire                   req_ready_o,
    input wire [2:0]             req_op_i,
    input wire                   rsp_valid_o,
    input wire [`FBH_ADDR_W-1:0] flash_addr_o,
    input wire                   flash_dq_oe_o,
    input wire                   flash_ce_n_o,
    input wire                   flash_oe_n_o,
    input wire                   flash_we_n_o,
    input wire                   flash_hv_id_o
);
    logic [3:0] oe_low, we_low;
    // low-time counters saturate so a strobe low in reset never looks short
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_low <= 4'hf;
            we_low <= 4'hf;
        end else begin
            oe_low <= flash_oe_n_o ? 4'h0 : oe_low + {3'h0, oe_low != 4'hf};
            we_low <= flash_we_n_o ? 4'h0 : we_low + {3'h0, we_low != 4'hf};
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_take;
        ce_i && req_valid_i && req_ready_o;
    endsequence
    sequence s_read_take;
        s_take ##0 req_op_i == `FBH_OP_READ;
    endsequence
    a_write_levels: assert property (
        $fell(flash_we_n_o) |-> !flash_ce_n_o && flash_oe_n_o)
        else $error("write strobe fell outside the write level set");
    a_read_strobe: assert property (
        !flash_ce_n_o && !flash_oe_n_o |-> flash_we_n_o)
        else $error("write strobe low during a read");
    a_no_contention: assert property (flash_dq_oe_o |-> flash_oe_n_o)
        else $error("host drives data while output gate low");
    a_access_time: assert property ($rose(flash_oe_n_o) |-> oe_low >= ACCESS_CYC)
        else $error("output gate low shorter than access time");
    a_pulse_width: assert property ($rose(flash_we_n_o) |-> we_low >= PULSE_CYC)
        else $error("write pulse too short");
    a_addr_hold: assert property (
        !flash_we_n_o && $past(!flash_we_n_o) |-> $stable(flash_addr_o))
        else $error("address moved during write pulse");
    a_hv_read_only: assert property (flash_hv_id_o |-> flash_we_n_o)
        else $error("write while high-voltage qualifier set");
    a_freeze_hold: assert property (
        !ce_i |=> $stable(flash_ce_n_o) && $stable(flash_oe_n_o) && $stable(flash_we_n_o)
                  && $stable(flash_addr_o) && $stable(rsp_valid_o))
        else $error("pins moved while clock enable low");
    a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    a_read_answer: assert property (s_read_take |=> !req_ready_o ##[5:40] rsp_valid_o)
        else $error("read answer missing");
endmodule
bind fbh_host fbh_host_sva #(.ACCESS_CYC(ACCESS_CYC), .PULSE_CYC(PULSE_CYC)) u_fbh_host_sva (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_op_i(req_op_i), .rsp_valid_o(rsp_valid_o),
    .flash_addr_o(flash_addr_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o), .flash_hv_id_o(flash_hv_id_o));

// ---- tb/fbh_host_tb_top.sv ----
// self-checking bench: flash host against a behavioural flash
`timescale 1ns/1ps
`include "fbh_consts.vh"
module fbh_host_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        ce_i      = 1'b1;
    logic        req_valid = 1'b0;
    logic [2:0]  req_op    = 3'h0;
    logic [18:0] req_addr  = 19'h0;
    logic [7:0]  req_data  = 8'h0;
    wire         req_ready, rsp_valid, id_mode, dq_oe, ce_n, oe_n, we_n, hv_id;
    wire  [7:0]  rsp_data, host_dq, dev_dq;
    wire  [18:0] fl_addr;
    logic [8:0]  expq [$];
    logic [8:0]  e;
    logic [7:0]  codes [0:3] = '{8'h5a, 8'hc3, 8'h01, 8'h11}; // maker and device arbitrary
    logic [31:0] seed = 32'd29;
    logic [31:0] r;
    logic [18:0] pa;
    logic [7:0]  pd;
    int          bad_count = 0, cmp_count = 0, rsp_cnt = 0, sent = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    fbh_host u_fbh_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_op_i(req_op),
        .req_addr_i(req_addr), .req_data_i(req_data), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data), .id_mode_o(id_mode), .flash_addr_o(fl_addr),
        .flash_dq_o(host_dq), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_oe ? host_dq : dev_dq),
        .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_hv_id_o(hv_id));
    fbh_flash_model #(.PROT_MASK(8'h20)) u_fbh_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .hv_id_i(hv_id), .addr_i(fl_addr), .dq_i(host_dq), .dq_o(dev_dq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // bit 8 of the note marks a response whose data is compared
    task automatic op(input logic [2:0] o, input logic [18:0] a, input logic [7:0] d,
                      input logic [8:0] x);
        int n;
        expq.push_back(x);
        sent++;
        @(posedge ref_clk_i);
        #2;
        {req_op, req_addr, req_data, req_valid} = {o, a, d, 1'b1};
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk_i);
            n++;
        end
        // never taken: skip the response wait and report it missing
        if (req_ready !== 1'b1)
            n = 500;
        @(posedge ref_clk_i);
        #2;
        req_valid = 1'b0;
        while (rsp_cnt < sent && n < 500) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (rsp_cnt < sent) begin
            bad_count++;
            $display("unexpected at %0t: no response", $time);
            stop_test();
        end
    endtask
    always @(posedge ref_clk_i) begin
        if (rsp_valid === 1'b1) begin
            rsp_cnt++;
            e = (expq.size() > 0) ? expq.pop_front() : 9'h1ee;
            if (e[8])
                check(rsp_data, e[7:0]);
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        #2;
        rstn_i = 1'b1;
        r  = rnd();
        pa = {3'h2, r[15:0]};
        r  = rnd();
        pd = {1'b0, r[6:0]};
        op(`FBH_OP_READ, pa, 8'h00, 9'h1ff);
        op(`FBH_OP_PROGRAM, pa, pd, 9'h000);
        op(`FBH_OP_READ, pa, 8'h00, 9'h180);
        repeat (40) @(posedge ref_clk_i);
        op(`FBH_OP_READ, pa, 8'h00, {1'b1, pd});
        op(`FBH_OP_PROGRAM, {3'h5, pa[15:0]}, pd, 9'h000);
        repeat (40) @(posedge ref_clk_i);
        op(`FBH_OP_READ, {3'h5, pa[15:0]}, 8'h00, 9'h1ff);
        op(`FBH_OP_AUTOSEL, 19'h0, 8'h00, 9'h000);
        check({7'h0, id_mode}, 8'h01);
        for (int i = 0; i < 4; i++)
            op(`FBH_OP_READ, {3'h5, 14'h0, i[1:0]}, 8'h00, {1'b1, codes[i]});
        op(`FBH_OP_READ, {3'h2, 16'h0002}, 8'h00, 9'h100);
        op(`FBH_OP_RESET, 19'h0, 8'h00, 9'h000);
        check({7'h0, id_mode}, 8'h00);
        op(`FBH_OP_READ, pa, 8'h00, {1'b1, pd});
        for (int i = 0; i < 4; i++)
            op(`FBH_OP_HV_ID, {3'h5, 14'h0, i[1:0]}, 8'h00, {1'b1, codes[i]});
        op(`FBH_OP_SECT_ERASE, {3'h2, 16'h0}, 8'h00, 9'h000);
        repeat (40) @(posedge ref_clk_i);
        op(`FBH_OP_READ, pa, 8'h00, 9'h1ff);
        op(`FBH_OP_WRITE, 19'h0, `FBH_CMD_RESET, 9'h000);
        #2;
        ce_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #2;
        ce_i = 1'b1;
        op(`FBH_OP_CHIP_ERASE, 19'h0, 8'h00, 9'h000);
        repeat (40) @(posedge ref_clk_i);
        // freeze the host while its read strobes are low
        fork
            op(`FBH_OP_READ, pa ^ 19'h1, 8'h00, 9'h1ff);
            begin
                repeat (5) @(posedge ref_clk_i);
                #2;
                ce_i = 1'b0;
                repeat (3) @(posedge ref_clk_i);
                #2;
                ce_i = 1'b1;
            end
        join
        stop_test();
    end
endmodule
